// ===== rtl/sac_pkg.sv
// Purpose: shared constants and types of the step attenuator host controller
// Assumes: pclk at 50 MHz; APB slave with 32-bit data, one aligned word per register
// Notes:   timing counts are derived from the printed nanosecond figures
package sac_pkg;

    localparam int PCLK_MHZ = 50;

    // pin timing of the attenuator, in ns or MHz as printed
    localparam int SCLK_MAX_MHZ       = 10;
    localparam int SCLK_MIN_PHASE_NS  = 30;
    localparam int SER_LE_SETUP_NS    = 10;
    localparam int SER_LE_PULSE_NS    = 30;
    localparam int PAR_LE_PULSE_NS    = 10;
    localparam int PAR_DATA_SETUP_NS  = 10;
    localparam int PAR_DATA_HOLD_NS   = 10;

    // least times round up to whole pclk cycles, never below one
    function automatic int ns_to_min_cyc(input int ns);
        int c;
        c = (ns * PCLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SCLK_PERIOD_NS    = 1000 / SCLK_MAX_MHZ;
    localparam int SCLK_HALF_A       = ns_to_min_cyc(SCLK_MIN_PHASE_NS);
    localparam int SCLK_HALF_B       = (ns_to_min_cyc(SCLK_PERIOD_NS) + 1) / 2;
    localparam int SCLK_HALF_CYC     = (SCLK_HALF_A > SCLK_HALF_B) ? SCLK_HALF_A : SCLK_HALF_B;
    localparam int SER_LE_SETUP_CYC  = ns_to_min_cyc(SER_LE_SETUP_NS);
    localparam int SER_LE_PULSE_CYC  = ns_to_min_cyc(SER_LE_PULSE_NS);
    localparam int PAR_LE_PULSE_CYC  = ns_to_min_cyc(PAR_LE_PULSE_NS);
    localparam int PAR_SETUP_CYC     = ns_to_min_cyc(PAR_DATA_SETUP_NS);
    localparam int PAR_HOLD_CYC      = ns_to_min_cyc(PAR_DATA_HOLD_NS);

    // attenuation code and serial word
    localparam int         CODE_W        = 5;
    localparam int         WORD_W        = 6;
    localparam logic       START_BIT_VAL = 1'b0;
    localparam logic [4:0] CODE_RESET    = 5'h00;

    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CODE   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // CTRL fields
    localparam int   CTRL_SERIAL_BIT    = 0;
    localparam int   CTRL_DIRECT_BIT    = 1;
    localparam int   CTRL_PRESET_BIT    = 2;
    localparam logic CTRL_SERIAL_RESET  = 1'b0;
    localparam logic CTRL_DIRECT_RESET  = 1'b0;
    localparam logic CTRL_PRESET_RESET  = 1'b0;

    // STATUS fields
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_APPLIED_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PAR_SETUP,
        ST_SHIFT,
        ST_LE_SETUP,
        ST_STROBE_HI,
        ST_HOLD
    } sac_state_e;

endpackage

// ===== rtl/sac_serial_shifter.sv
// Purpose: sends one serial word to the attenuator, msb first, on a divided serial clock
// Assumes: HALF_CYC of at least 2, so data moves one cycle after a fall and settles before a rise
// Notes:   the serial clock idles low; done pulses in the same cycle as the last falling edge
`timescale 1ns/1ps
module sac_serial_shifter
    import sac_pkg::*;
#(
    parameter int WORD_BITS = WORD_W,
    parameter int HALF_CYC  = SCLK_HALF_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 start,
    input  wire logic [WORD_BITS-1:0] word,
    output logic                      busy,
    output logic                      done,
    output logic                      ser_clk,
    output logic                      ser_data
);

    localparam logic [3:0] HALF_M1 = 4'(HALF_CYC - 1);
    localparam logic [3:0] BITS    = 4'(WORD_BITS);

    typedef struct packed {
        logic                 busy;
        logic                 done;
        logic                 sclk;
        logic                 sdata;
        logic                 pend;
        logic [3:0]           cnt;
        logic [3:0]           left;
        logic [WORD_BITS-1:0] sr;
    } sac_shift_s;

    sac_shift_s s_q;
    sac_shift_s s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy) begin
            if (start) begin
                s_d.busy  = 1'b1;
                s_d.sdata = word[WORD_BITS-1];
                s_d.sr    = {word[WORD_BITS-2:0], 1'b0};
                s_d.left  = BITS;
                s_d.cnt   = 4'h0;
                s_d.sclk  = 1'b0;
                s_d.pend  = 1'b0;
            end
        end else if (!s_q.sclk) begin
            // next bit moves one cycle after the fall, keeping hold time after the edge
            if (s_q.pend) begin
                s_d.sdata = s_q.sr[WORD_BITS-1];
                s_d.sr    = {s_q.sr[WORD_BITS-2:0], 1'b0};
                s_d.pend  = 1'b0;
            end
            if (s_q.cnt == HALF_M1) begin
                s_d.sclk = 1'b1;
                s_d.cnt  = 4'h0;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end else begin
            if (s_q.cnt == HALF_M1) begin
                s_d.sclk = 1'b0;
                s_d.cnt  = 4'h0;
                s_d.left = s_q.left - 4'h1;
                if (s_q.left == 4'h1) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end else begin
                    s_d.pend = 1'b1;
                end
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy     = s_q.busy;
    assign done     = s_q.done;
    assign ser_clk  = s_q.sclk;
    assign ser_data = s_q.sdata;

endmodule

// ===== rtl/sac_host.sv
// Purpose: host controller that programs a 5-bit step attenuator through its pins
// Assumes: APB master on pclk; zero-wait slave; attenuator pins are plain outputs
// Notes:   the serial clock is made here by division, so there is no second clock domain
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - latched parallel: strobe low while lines change, then pulse high and low.
// - shift the whole word with strobe low, then pulse strobe high and low.
// - the leading start bit is always sent as zero.
// - word goes msb first: start bit, 8, 4, 2, 1, 0.5 dB weights.
// - serial clock at most 10 MHz, each phase at least 30 ns.
// - wait at least 10 ns after the last falling clock before raising strobe.
module sac_host
    import sac_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   interface_select,
    output logic                   load_strobe,
    output logic                   powerup_preset_select,
    output logic                   weight_8db_bit,
    output logic                   weight_4db_bit,
    output logic                   weight_2db_bit,
    output logic                   weight_1db_bit,
    output logic                   weight_half_db_bit,
    output logic                   ser_clk,
    output logic                   ser_data
);

    localparam logic [2:0] SER_LE_SETUP_M1 = 3'(SER_LE_SETUP_CYC - 1);
    localparam logic [2:0] SER_LE_PULSE_M1 = 3'(SER_LE_PULSE_CYC - 1);
    localparam logic [2:0] PAR_LE_PULSE_M1 = 3'(PAR_LE_PULSE_CYC - 1);
    localparam logic [2:0] PAR_SETUP_M1    = 3'(PAR_SETUP_CYC - 1);
    localparam logic [2:0] PAR_HOLD_M1     = 3'(PAR_HOLD_CYC - 1);

    typedef struct packed {
        sac_state_e        st;
        logic [2:0]        cnt;
        logic              serial_mode;
        logic              direct_mode;
        logic              preset_sel;
        logic [CODE_W-1:0] code;
        logic [CODE_W-1:0] applied;
        logic [CODE_W-1:0] pin_code;
        logic              strobe;
        logic              start;
        logic              refused;
        logic [31:0]       rdata;
    } sac_host_s;

    sac_host_s s_q;
    sac_host_s s_d;

    logic              sh_busy;
    logic              sh_done;
    logic [WORD_W-1:0] ser_word;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return reg_hit(a, REG_CTRL) || reg_hit(a, REG_CODE) || reg_hit(a, REG_STATUS);
    endfunction

    // the start bit is forced low; a one there would leave the part undefined
    assign ser_word = {START_BIT_VAL, s_q.code};

    logic apb_access;
    logic apb_setup;
    logic idle;
    logic wr_ctrl;
    logic wr_code;
    logic wr_stat;
    logic busy_write;

    always_comb begin
        apb_access = psel && penable;
        apb_setup  = psel && !penable;
        idle       = (s_q.st == ST_IDLE);
        wr_ctrl    = apb_access && pwrite && reg_hit(paddr, REG_CTRL);
        wr_code    = apb_access && pwrite && reg_hit(paddr, REG_CODE);
        wr_stat    = apb_access && pwrite && reg_hit(paddr, REG_STATUS);
        // a mode or code change mid-sequence would corrupt the pin timing, so it is refused
        busy_write = (wr_ctrl || wr_code) && !idle;
    end

    always_comb begin
        s_d       = s_q;
        s_d.start = 1'b0;

        if (apb_setup) begin
            s_d.rdata = 32'h0000_0000;
            if (reg_hit(paddr, REG_CTRL)) begin
                s_d.rdata[CTRL_SERIAL_BIT] = s_q.serial_mode;
                s_d.rdata[CTRL_DIRECT_BIT] = s_q.direct_mode;
                s_d.rdata[CTRL_PRESET_BIT] = s_q.preset_sel;
            end else if (reg_hit(paddr, REG_CODE)) begin
                s_d.rdata[CODE_W-1:0] = s_q.code;
            end else if (reg_hit(paddr, REG_STATUS)) begin
                s_d.rdata[STAT_BUSY_BIT]                              = !idle;
                s_d.rdata[STAT_REFUSED_BIT]                           = s_q.refused;
                s_d.rdata[STAT_APPLIED_LSB +: CODE_W]                 = s_q.applied;
            end
        end

        // write-one-to-clear; a fresh refusal in the same cycle wins
        if (wr_stat && pwdata[STAT_REFUSED_BIT]) begin
            s_d.refused = 1'b0;
        end
        if (busy_write) begin
            s_d.refused = 1'b1;
        end

        if (wr_ctrl && idle) begin
            s_d.serial_mode = pwdata[CTRL_SERIAL_BIT];
            s_d.direct_mode = pwdata[CTRL_DIRECT_BIT];
            s_d.preset_sel  = pwdata[CTRL_PRESET_BIT];
        end

        case (s_q.st)
            ST_IDLE: begin
                if (!s_q.serial_mode && s_q.direct_mode) begin
                    // direct mode: strobe stays high and the lines follow the code
                    s_d.strobe   = 1'b1;
                    s_d.pin_code = s_q.code;
                    s_d.applied  = s_q.code;
                end else begin
                    s_d.strobe = 1'b0;
                end
                if (wr_code) begin
                    s_d.code = pwdata[CODE_W-1:0];
                    if (s_q.serial_mode) begin
                        s_d.start = 1'b1;
                        s_d.st    = ST_SHIFT;
                    end else if (!s_q.direct_mode) begin
                        // lines change with the strobe low, setup counted before the rise
                        s_d.pin_code = pwdata[CODE_W-1:0];
                        s_d.cnt      = PAR_SETUP_M1;
                        s_d.st       = ST_PAR_SETUP;
                    end
                end
            end
            ST_PAR_SETUP: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.strobe = 1'b1;
                    s_d.cnt    = PAR_LE_PULSE_M1;
                    s_d.st     = ST_STROBE_HI;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_SHIFT: begin
                // strobe stays low so the attenuator never sees a partial word
                if (sh_done) begin
                    s_d.cnt = SER_LE_SETUP_M1;
                    s_d.st  = ST_LE_SETUP;
                end
            end
            ST_LE_SETUP: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.strobe = 1'b1;
                    s_d.cnt    = SER_LE_PULSE_M1;
                    s_d.st     = ST_STROBE_HI;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_STROBE_HI: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.strobe = 1'b0;
                    s_d.cnt    = PAR_HOLD_M1;
                    s_d.st     = ST_HOLD;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_HOLD: begin
                // parallel lines are held past the strobe fall; serial mode mirrors them too
                if (s_q.cnt == 3'h0) begin
                    s_d.pin_code = s_q.code;
                    s_d.applied  = s_q.code;
                    s_d.st       = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            default: begin
                s_d.st     = ST_IDLE;
                s_d.strobe = 1'b0;
            end
        endcase
    end

    // reset pins set up the power-up preset: parallel, strobe low, select low, lines zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q             <= '0;
            s_q.st          <= ST_IDLE;
            s_q.serial_mode <= CTRL_SERIAL_RESET;
            s_q.direct_mode <= CTRL_DIRECT_RESET;
            s_q.preset_sel  <= CTRL_PRESET_RESET;
            s_q.code        <= CODE_RESET;
            s_q.applied     <= CODE_RESET;
            s_q.pin_code    <= CODE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    sac_serial_shifter #(
        .WORD_BITS (WORD_W),
        .HALF_CYC  (SCLK_HALF_CYC)
    ) u_shift (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (s_q.start),
        .word     (ser_word),
        .busy     (sh_busy),
        .done     (sh_done),
        .ser_clk  (ser_clk),
        .ser_data (ser_data)
    );

    logic unused_busy;
    assign unused_busy = sh_busy;

    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = apb_access && (!addr_mapped(paddr) || busy_write);

    assign interface_select      = s_q.serial_mode;
    assign load_strobe           = s_q.strobe;
    assign powerup_preset_select = s_q.preset_sel;
    assign weight_8db_bit        = s_q.pin_code[4];
    assign weight_4db_bit        = s_q.pin_code[3];
    assign weight_2db_bit        = s_q.pin_code[2];
    assign weight_1db_bit        = s_q.pin_code[1];
    assign weight_half_db_bit    = s_q.pin_code[0];

endmodule

// ===== verification/sac_host_monitor.sv
// Purpose: pin checks of the attenuator host controller, against writes seen on the bus
// Assumes: one pclk domain; the serial clock is a divided pin, not a clock
// Notes:   the expected serial word is the last CODE write seen on the bus
`timescale 1ns/1ps
module sac_host_monitor
    import sac_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              interface_select,
    input wire logic              load_strobe,
    input wire logic              weight_8db_bit,
    input wire logic              weight_4db_bit,
    input wire logic              weight_2db_bit,
    input wire logic              weight_1db_bit,
    input wire logic              weight_half_db_bit,
    input wire logic              ser_clk,
    input wire logic              ser_data
);
    typedef struct packed {
        logic       ser_q;
        logic [2:0] rises;
        logic [4:0] code_w;
        logic       direct;
    } sac_mon_s;

    sac_mon_s   mon_q;
    sac_mon_s   mon_d;
    logic [4:0] wts;
    logic [5:0] word;

    assign wts  = {weight_8db_bit, weight_4db_bit, weight_2db_bit, weight_1db_bit, weight_half_db_bit};
    assign word = {1'b0, mon_q.code_w};

    // rises since the last strobe give the index of the bit being sent
    always_comb begin
        mon_d = mon_q;
        mon_d.ser_q = ser_clk;
        if (load_strobe)
            mon_d.rises = 3'd0;
        else if (ser_clk && !mon_q.ser_q)
            mon_d.rises = mon_q.rises + 3'd1;
        if (psel && penable && pwrite && pready) begin
            if (paddr == ADDR_W'(REG_CODE))
                mon_d.code_w = pwdata[4:0];
            if (paddr == ADDR_W'(REG_CTRL))
                mon_d.direct = pwdata[CTRL_DIRECT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mon_q <= '0;
        else
            mon_q <= mon_d;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence clk_high_s;  ser_clk [*3]; endsequence
    sequence clk_low_s;   !ser_clk [*3]; endsequence
    sequence ser_pulse_s; load_strobe [*2] ##1 !load_strobe; endsequence
    sequence par_pulse_s; $stable(wts) ##1 (!load_strobe && $stable(wts)) ##1 $stable(wts); endsequence

    ser_hi_phase_a: assert property ($rose(ser_clk) |-> clk_high_s)
        else $error("serial clock high phase too short");
    ser_lo_phase_a: assert property ($fell(ser_clk) |-> clk_low_s)
        else $error("serial clock low phase too short");
    le_after_clk_a: assert property ($fell(ser_clk) |-> !load_strobe [*2])
        else $error("strobe raised too soon after serial clock fall");
    le_low_shift_a: assert property (ser_clk |-> !load_strobe)
        else $error("strobe high while shifting");
    data_steady_a: assert property (($rose(ser_clk) || $fell(ser_clk)) |-> $stable(ser_data))
        else $error("serial data moved at a serial clock edge");
    word_order_a: assert property ($rose(ser_clk) |-> ser_data == word[3'd5 - mon_q.rises])
        else $error("serial bit out of order");
    word_len_a: assert property ($rose(load_strobe) && interface_select |-> mon_q.rises == 3'd6)
        else $error("serial word not six bits");
    ser_pulse_a: assert property ($rose(load_strobe) && interface_select |-> ser_pulse_s)
        else $error("serial strobe pulse wrong");
    par_pulse_a: assert property ($rose(load_strobe) && !interface_select && !mon_q.direct |-> par_pulse_s)
        else $error("parallel strobe pulse or data hold wrong");
    par_no_clk_a: assert property (!interface_select |-> !ser_clk)
        else $error("serial clock active in parallel mode");
endmodule

bind sac_host sac_host_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .interface_select(interface_select), .load_strobe(load_strobe),
    .weight_8db_bit(weight_8db_bit), .weight_4db_bit(weight_4db_bit), .weight_2db_bit(weight_2db_bit),
    .weight_1db_bit(weight_1db_bit), .weight_half_db_bit(weight_half_db_bit), .ser_clk(ser_clk),
    .ser_data(ser_data));

// ===== verification/sac_atten_model.sv
// Purpose: behavioural model of the attenuator control logic
// Assumes: power_up rising stands for applying supply
// Notes:   code is the attenuation in half dB steps
`timescale 1ns/1ps
module sac_atten_model (
    input  wire logic       power_up,
    input  wire logic       interface_select,
    input  wire logic       load_strobe,
    input  wire logic       powerup_preset_select,
    input  wire logic [4:0] weights,
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    output logic      [4:0] code
);
    logic [5:0] shreg;

    // shifting ignores the strobe level
    always @(posedge ser_clk) shreg <= {shreg[4:0], ser_data};

    // a set start bit leaves the state undefined, shown as unknown
    // one process owns code; the power-up pulse takes priority while it stands
    always @(power_up or load_strobe or interface_select or shreg or weights) begin
        if (power_up && (interface_select || load_strobe))
            code = weights;
        else if (power_up)
            code = powerup_preset_select ? 5'h10 : 5'h00;
        else if (load_strobe)
            code = interface_select ? (shreg[5] !== 1'b0 ? 'x : shreg[4:0]) : weights;
    end
endmodule

// ===== verification/step_attenuator_control_interface_tb.sv
// Purpose: self-checking bench of the attenuator host over APB
// Assumes: zero-wait slave; device modelled by sac_atten_model
// Notes:   busy is polled, never timed
`timescale 1ns/1ps
module step_attenuator_control_interface_tb;
    import sac_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, power_up, pready, pslverr;
    logic        sel, ls, pps, ser_clk, ser_data, armed;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [4:0]  wts, m_code, last, mc, c;
    logic [32:0] res, exp_q[$];
    logic [4:0]  code_q[$];
    int          errors, n_checks;
    event        rd_ev;

    sac_host #(.ADDR_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .interface_select(sel), .load_strobe(ls), .powerup_preset_select(pps),
        .weight_8db_bit(wts[4]), .weight_4db_bit(wts[3]), .weight_2db_bit(wts[2]),
        .weight_1db_bit(wts[1]), .weight_half_db_bit(wts[0]), .ser_clk(ser_clk), .ser_data(ser_data));
    sac_atten_model u_dev (.power_up(power_up), .interface_select(sel), .load_strobe(ls),
        .powerup_preset_select(pps), .weights(wts), .ser_clk(ser_clk), .ser_data(ser_data), .code(m_code));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_word(input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error bus word expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_code(input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error device code expected %h seen %h", e, g);
        end
    endtask
    always @(rd_ev) chk_word(exp_q.pop_front(), res);
    always @(negedge pclk) if (armed && m_code !== last) begin
        last = m_code;
        // a change nobody announced is compared against unknown, so it fails unless the new code is all unknown
        chk_code((code_q.size() > 0) ? code_q.pop_front() : 5'hx, m_code);
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit chk, input logic [32:0] e);
        logic err;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (chk) begin
            exp_q.push_back(e);
            res = {err, w ? 32'h0 : rd};
            ->rd_ev;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        apb(1'b1, a, d, 1'b1, e);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, 1'b1, e);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, 1'b0, 33'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 200);
        if (rd[STAT_BUSY_BIT] !== 1'b0) begin
            errors++;
            $display("Error status busy expected 0 seen %b", rd[STAT_BUSY_BIT]);
        end
    endtask
    task automatic expect_code(input logic [4:0] v);
        if (v !== mc) code_q.push_back(v);
        mc = v;
    endtask
    task automatic pwr(input logic [4:0] v);
        expect_code(v);
        @(posedge pclk) power_up <= 1'b1;
        @(posedge pclk) power_up <= 1'b0;
    endtask
    task automatic load(input logic [4:0] v, input bit st);
        expect_code(v);
        wr(REG_CODE, {27'h0, v}, 33'h0);
        wait_idle();
        if (st) rdx(REG_STATUS, {20'h0, v, 8'h00});
        rdx(REG_CODE, {28'h0, v});
    endtask
    task automatic sweep(input bit st);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            c = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : (i == 2) ? 5'h15 : seed[4:0];
            load(c, st);
        end
    endtask
    task automatic complete_run;
        // a note still queued means an expected result never appeared
        if (code_q.size() + exp_q.size() > 0) begin
            errors++;
            $display("Error pending notes expected 0 seen %0d", code_q.size() + exp_q.size());
        end
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        complete_run();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        power_up = 1'b0; seed = 32'h65d5; last = 'x; mc = 'x; armed = 1'b1; errors = 0; n_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdx(REG_CTRL, 33'h0);
        rdx(REG_STATUS, 33'h0);
        rdx(8'h0c, 33'h1_0000_0000);
        pwr(5'h00);
        wr(REG_CTRL, 32'h4, 33'h0);
        rdx(REG_CTRL, 33'h4);
        pwr(5'h10);
        $display("test powerup done");
        expect_code(CODE_RESET);
        wr(REG_CTRL, 32'h6, 33'h0);
        pwr(5'h00);
        sweep(1'b0);
        $display("test direct done");
        wr(REG_CTRL, 32'h0, 33'h0);
        sweep(1'b1);
        $display("test latched done");
        wr(REG_CTRL, 32'h1, 33'h0);
        pwr(mc);
        sweep(1'b1);
        $display("test serial done");
        expect_code(5'h0a);
        wr(REG_CODE, 32'h0a, 33'h0);
        wr(REG_CTRL, 32'h1, 33'h1_0000_0000);
        wait_idle();
        rdx(REG_STATUS, 33'h0a02);
        wr(REG_STATUS, 32'h2, 33'h0);
        rdx(REG_STATUS, 33'h0a00);
        rdx(REG_CTRL, 33'h1);
        $display("test refusal done");
        repeat (4) @(posedge pclk);
        complete_run();
    end
endmodule
